// ==== hdl/spm_pkg.sv ====
/*
  Shared constants and types of the multiprocessor serial port.
  Assumes one clock, mclk, that also stands in for the device oscillator.
*/
package spm_pkg;
  // Special function register addresses
  localparam logic [7:0] SPM_CTRL_ADDR = 8'h98;
  localparam logic [7:0] SPM_BUF_ADDR_DEF = 8'h99;
  // Field positions in serial_control
  localparam int SPM_MODE0_POS = 7;
  localparam int SPM_MODE1_POS = 6;
  localparam int SPM_MPEN_POS = 5;
  localparam int SPM_RXEN_POS = 4;
  localparam int SPM_TX9_POS = 3;
  localparam int SPM_RX9_POS = 2;
  localparam int SPM_TXDONE_POS = 1;
  localparam int SPM_RXDONE_POS = 0;
  localparam logic [7:0] SPM_CTRL_RST = 8'h00;
  // Modes as {mode_select_bit0, mode_select_bit1}
  localparam logic [1:0] SPM_MODE_SYNC = 2'h0;
  localparam logic [1:0] SPM_MODE_UART8 = 2'h1;
  localparam logic [1:0] SPM_MODE_UART9F = 2'h2;
  // Shift clock: one bit per twelve oscillator cycles, rising edge at half
  localparam logic [3:0] SPM_SYNC_LAST = 4'hb;
  localparam logic [3:0] SPM_SYNC_HALF = 4'h6;
  // Sixteen sample ticks per async bit, sample point in the middle
  localparam logic [3:0] SPM_OS_MID = 4'h7;
  // Fixed-rate mode: tick every 4 (1/64) or 2 (1/32) oscillator cycles
  localparam logic [1:0] SPM_M2_SLOW_LAST = 2'h3;
  // Frame lengths in bits, start and stop included for async frames; sync frames are 8 data bits only
  localparam logic [3:0] SPM_FRAME8 = 4'ha;
  localparam logic [3:0] SPM_FRAME9 = 4'hb;
  localparam logic [3:0] SPM_SYNC_BITS = 4'h8;
  localparam int SPM_FIFO_DEPTH = 16;

  typedef enum logic [2:0] {
    SPM_TX_IDLE = 3'b001,
    SPM_TX_ASYNC = 3'b010,
    SPM_TX_SYNC = 3'b100
  } spm_tx_e;

  typedef enum logic [2:0] {
    SPM_RX_IDLE = 3'b001,
    SPM_RX_ASYNC = 3'b010,
    SPM_RX_SYNC = 3'b100
  } spm_rx_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } spm_sfr_s;

  typedef struct packed {
    logic ninth;
    logic [7:0] data;
  } spm_txw_s;
endpackage

// ==== hdl/spm_serial_port.sv ====
/*
  Serial port with sync shift mode, three async modes, transmit FIFO,
  double-buffered receiver, framing error and ninth-bit address filter.
  Assumes all inputs are synchronous to mclk and baud_tick16 is a one-cycle
  pulse at sixteen times the variable bit rate.
*/
`timescale 1ns/1ns
`default_nettype none

module spm_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q, rd_ptr_q;
  logic [AW:0] count_q, count_d;
  logic push, pop;

  // Ready is a flop so that a full buffer refuses on the very next write
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (count_q != '0);
  assign out_data = mem_q[rd_ptr_q];
  assign count_d = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  // Pointers and occupancy
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      in_ready <= 1'b1;
    end else begin
      if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop) rd_ptr_q <= rd_ptr_q + 1'b1;
      count_q <= count_d;
      in_ready <= (count_d != (AW+1)'(DEPTH));
    end
  end

  // Storage, no reset needed on data
  always_ff @(posedge mclk) begin
    if (push) mem_q[wr_ptr_q] <= in_data;
  end
endmodule

// Notes on behaviour
// - Transmit and receive run independently, concurrently, in async modes; sync mode waits for the other side to idle
// - Receiver accepts new frame before old read
// - Buffer write loads transmit, read gives receive
// - Sync mode: 8 bits LSB first, clock/12
// - Mode 1: start, 8 data, stop into ninth
// - Modes 2/3: start, 8 data, ninth, stop
// - Sent ninth bit is the software value
// - Mode 2 rate is osc/64 or osc/32
// - Mode 3 equals mode 2, variable rate
// - Any buffer write queues a transmission, except a write to a full queue, which is dropped
// - Sync receive starts when done clear, enabled
// - Async receive starts on start bit, enabled
// - Missing stop bit sets framing error
// - Framing error sticks until software clears
// - Control bit 7 is mode bit or error
// - Ninth bit one for address, zero data
// - Address filter passes only ninth-bit-one frames
module spm_serial_port
  import spm_pkg::*;
#(
  parameter logic [7:0] BUF_ADDR = SPM_BUF_ADDR_DEF,
  parameter int FIFO_DEPTH = SPM_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Special function register access
  input wire spm_sfr_s sfr_req,
  output logic [7:0] sfr_rdata,
  output logic tx_fifo_ready,
  // Bits of power_control and the rate source
  input wire logic err_access_select,
  input wire logic baud_double,
  input wire logic baud_tick16,
  // Serial pins
  output logic txd,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  // Interrupt request
  output logic serial_irq
);
  logic [7:0] ctrl_q, ctrl_d, rx_buf_q;
  logic fe_q, fe_d;
  logic [1:0] mode;
  logic mode_sync, nine_mode, tick16, ctrl_wr, buf_wr;
  logic [3:0] sync_cnt_q;
  logic [1:0] m2_cnt_q;
  logic sync_fall, sync_rise, m2_tick, sync_clk_q, sync_active;
  spm_tx_e tx_state_q;
  logic [10:0] tx_shift_q;
  logic [3:0] tx_bits_q, tx_os_q;
  logic tx_line_q, tx_start, tx_end, tx_os_hit;
  spm_txw_s fifo_in, fifo_out;
  logic fifo_valid;
  spm_rx_e rx_state_q;
  logic [9:0] rx_shift_q;
  logic [3:0] rx_bits_q, rx_os_q;
  logic rxd_prev_q, rx_mid, async_end, sync_end, rx_store, rx_ferr;
  logic [7:0] rx_data;
  logic rx_ninth;

  // Mode and register decode
  assign mode = {ctrl_q[SPM_MODE0_POS], ctrl_q[SPM_MODE1_POS]};
  assign mode_sync = (mode == SPM_MODE_SYNC);
  assign nine_mode = mode[1];
  assign ctrl_wr = sfr_req.wr && (sfr_req.addr == SPM_CTRL_ADDR);
  assign buf_wr = sfr_req.wr && (sfr_req.addr == BUF_ADDR);

  // Rate dividers: sync clock phases and the fixed-rate sample tick
  assign sync_fall = (sync_cnt_q == 4'h0);
  assign sync_rise = (sync_cnt_q == SPM_SYNC_HALF);
  assign m2_tick = baud_double ? m2_cnt_q[0] : (m2_cnt_q == SPM_M2_SLOW_LAST);
  assign tick16 = (mode == SPM_MODE_UART9F) ? m2_tick : baud_tick16;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync_cnt_q <= 4'h0;
      m2_cnt_q <= 2'h0;
    end else begin
      sync_cnt_q <= (sync_cnt_q == SPM_SYNC_LAST) ? 4'h0 : sync_cnt_q + 4'h1;
      m2_cnt_q <= m2_cnt_q + 2'h1;
    end
  end

  // Transmit FIFO; a write while full is dropped, seen on tx_fifo_ready
  assign fifo_in = '{ninth: ctrl_q[SPM_TX9_POS], data: sfr_req.wdata};
  spm_fifo #(.WIDTH($bits(spm_txw_s)), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .mclk(mclk),
    .rst(rst),
    .in_valid(buf_wr),
    .in_data(fifo_in),
    .in_ready(tx_fifo_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_out),
    .out_ready(tx_start)
  );

  // Sync mode shares the pins, so a send waits for the receiver to idle
  assign tx_start = (tx_state_q == SPM_TX_IDLE) && fifo_valid &&
                    (!mode_sync || rx_state_q == SPM_RX_IDLE);
  assign tx_os_hit = tick16 && (tx_os_q == 4'h0);
  assign tx_end = ((tx_state_q == SPM_TX_ASYNC) && tx_os_hit && tx_bits_q == 4'h0) ||
                  ((tx_state_q == SPM_TX_SYNC) && sync_fall && tx_bits_q == 4'h0);

  // Transmitter
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_state_q <= SPM_TX_IDLE;
      tx_shift_q <= 11'h7ff;
      tx_bits_q <= 4'h0;
      tx_os_q <= 4'h0;
      tx_line_q <= 1'b1;
      rxd_out <= 1'b1;
      rxd_oe <= 1'b0;
    end else begin
      case (tx_state_q)
        SPM_TX_IDLE: begin
          tx_os_q <= 4'h0;
          if (tx_start && mode_sync) begin
            tx_shift_q <= {3'h7, fifo_out.data};
            tx_bits_q <= SPM_SYNC_BITS;
            tx_state_q <= SPM_TX_SYNC;
          end else if (tx_start) begin
            tx_shift_q <= {1'b1, nine_mode ? fifo_out.ninth : 1'b1, fifo_out.data, 1'b0};
            tx_bits_q <= nine_mode ? SPM_FRAME9 : SPM_FRAME8;
            tx_state_q <= SPM_TX_ASYNC;
          end
        end
        SPM_TX_ASYNC: begin
          if (tick16) tx_os_q <= tx_os_q + 4'h1;
          if (tx_end) begin
            tx_state_q <= SPM_TX_IDLE;
          end else if (tx_os_hit) begin
            tx_line_q <= tx_shift_q[0]; // LSB first
            tx_shift_q <= {1'b1, tx_shift_q[10:1]};
            tx_bits_q <= tx_bits_q - 4'h1;
          end
        end
        SPM_TX_SYNC: begin
          if (tx_end) begin
            rxd_oe <= 1'b0;
            rxd_out <= 1'b1;
            tx_state_q <= SPM_TX_IDLE;
          end else if (sync_fall) begin
            rxd_oe <= 1'b1;
            rxd_out <= tx_shift_q[0];
            tx_shift_q <= {1'b1, tx_shift_q[10:1]};
            tx_bits_q <= tx_bits_q - 4'h1;
          end
        end
        default: tx_state_q <= SPM_TX_IDLE;
      endcase
    end
  end

  // Shift clock on txd in sync mode, low half first; line otherwise
  assign sync_active = (tx_state_q == SPM_TX_SYNC && tx_bits_q != 4'h0) ||
                       (rx_state_q == SPM_RX_SYNC && rx_bits_q != 4'h0);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync_clk_q <= 1'b1;
      txd <= 1'b1;
    end else begin
      if (sync_fall && sync_active) sync_clk_q <= 1'b0;
      else if (sync_rise) sync_clk_q <= 1'b1;
      txd <= mode_sync ? ((sync_fall && sync_active) ? 1'b0 :
             (sync_rise ? 1'b1 : sync_clk_q)) : tx_line_q;
    end
  end

  // Receive completion; data and ninth bit sit differently per frame size
  assign rx_mid = tick16 && (rx_os_q == SPM_OS_MID);
  assign async_end = (rx_state_q == SPM_RX_ASYNC) && rx_mid && (rx_bits_q == 4'h1);
  assign sync_end = (rx_state_q == SPM_RX_SYNC) && sync_fall && (rx_bits_q == 4'h0);
  assign rx_data = mode_sync ? rx_shift_q[9:2] :
                   (nine_mode ? rx_shift_q[8:1] : rx_shift_q[9:2]);
  assign rx_ninth = nine_mode ? rx_shift_q[9] : rxd_in;
  // A full receive register makes the newer byte the one that is lost
  assign rx_store = !ctrl_q[SPM_RXDONE_POS] && (sync_end ||
                    (async_end && (!ctrl_q[SPM_MPEN_POS] || rx_ninth)));
  assign rx_ferr = async_end && !rxd_in;

  // Receiver
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_state_q <= SPM_RX_IDLE;
      rx_shift_q <= 10'h000;
      rx_bits_q <= 4'h0;
      rx_os_q <= 4'h0;
      rxd_prev_q <= 1'b1;
      rx_buf_q <= 8'h00;
    end else begin
      rxd_prev_q <= rxd_in;
      if (rx_store) rx_buf_q <= rx_data;
      case (rx_state_q)
        SPM_RX_IDLE: begin
          rx_os_q <= 4'h0;
          if (mode_sync && ctrl_q[SPM_RXEN_POS] && !ctrl_q[SPM_RXDONE_POS] &&
              tx_state_q == SPM_TX_IDLE && !fifo_valid) begin
            rx_bits_q <= SPM_SYNC_BITS;
            rx_state_q <= SPM_RX_SYNC;
          end else if (!mode_sync && ctrl_q[SPM_RXEN_POS] && rxd_prev_q && !rxd_in) begin
            rx_bits_q <= nine_mode ? SPM_FRAME9 : SPM_FRAME8;
            rx_state_q <= SPM_RX_ASYNC;
          end
        end
        SPM_RX_ASYNC: begin
          if (tick16) rx_os_q <= rx_os_q + 4'h1;
          if (rx_mid) begin
            rx_bits_q <= rx_bits_q - 4'h1;
            rx_shift_q <= {rxd_in, rx_shift_q[9:1]};
            // A start bit that is high again at mid-bit was a glitch
            if (async_end || (rx_bits_q == SPM_FRAME8 && !nine_mode && rxd_in) ||
                (rx_bits_q == SPM_FRAME9 && nine_mode && rxd_in)) begin
              rx_state_q <= SPM_RX_IDLE;
            end
          end
        end
        SPM_RX_SYNC: begin
          if (sync_end) begin
            rx_state_q <= SPM_RX_IDLE;
          end else if (sync_rise && !sync_clk_q && rx_bits_q != 4'h0) begin
            rx_shift_q <= {rxd_in, rx_shift_q[9:1]};
            rx_bits_q <= rx_bits_q - 4'h1;
          end
        end
        default: rx_state_q <= SPM_RX_IDLE;
      endcase
    end
  end

  // Control register; hardware sets beat a software clear in the same cycle
  assign ctrl_d = {
    (ctrl_wr && !err_access_select) ? sfr_req.wdata[7] : ctrl_q[7],
    ctrl_wr ? sfr_req.wdata[6:3] : ctrl_q[6:3],
    rx_store ? (mode_sync ? 1'b0 : rx_ninth) :
      (ctrl_wr ? sfr_req.wdata[2] : ctrl_q[2]),
    tx_end ? 1'b1 : (ctrl_wr ? sfr_req.wdata[1] : ctrl_q[1]),
    rx_store ? 1'b1 : (ctrl_wr ? sfr_req.wdata[0] : ctrl_q[0])
  };
  assign fe_d = rx_ferr ? 1'b1 :
                ((ctrl_wr && err_access_select) ? sfr_req.wdata[7] : fe_q);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_q <= SPM_CTRL_RST;
      fe_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      fe_q <= fe_d;
    end
  end

  // Registered read port and interrupt request
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
      serial_irq <= 1'b0;
    end else begin
      if (sfr_req.rd && sfr_req.addr == SPM_CTRL_ADDR) begin
        sfr_rdata <= {err_access_select ? fe_q : ctrl_q[7], ctrl_q[6:0]};
      end else if (sfr_req.rd && sfr_req.addr == BUF_ADDR) begin
        sfr_rdata <= rx_buf_q;
      end else if (sfr_req.rd) begin
        sfr_rdata <= 8'h00;
      end
      serial_irq <= ctrl_d[SPM_TXDONE_POS] || ctrl_d[SPM_RXDONE_POS];
    end
  end
endmodule

`default_nettype wire

// ==== verif/spm_remote_node.sv ====
/*
  Remote serial node facing the port: frame sender, frame and shift receiver.
  Assumes the bench resolves the shared data line and calls these tasks.
*/
`timescale 1ns/1ns
`default_nettype none

module spm_remote_node (
  // Clock
  input wire logic mclk,
  // Lines
  input wire logic txd,
  input wire logic rxd_line,
  output logic drive
);
  // Line idles high, as its pull-up holds it
  initial drive = 1'b1;

  // Bits go out LSB first, start bit in bit 0
  task automatic send(input logic [10:0] f, input int n, input int per);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      #1 drive = f[i];
      repeat (per - 1) @(posedge mclk);
    end
    @(posedge mclk);
    #1 drive = 1'b1;
  endtask

  // Mid-bit samples from the start edge; returns early to catch the next start
  task automatic get(input int n, input int per, output logic [10:0] f);
    int w;
    f = 'x;
    w = 0;
    while (txd === 1'b1 && w < 20000) begin
      @(negedge mclk);
      w++;
    end
    if (w == 20000) return;
    f = '0;
    repeat (per / 2) @(negedge mclk);
    for (int i = 0; i < n; i++) begin
      if (i > 0) repeat (per) @(negedge mclk);
      f[i] = txd;
    end
  endtask

  // Shift register peripheral: data taken on each clock rise
  task automatic get0(output logic [7:0] d);
    int w;
    int i;
    logic p;
    d = '0;
    w = 0;
    i = 0;
    p = txd;
    while (i < 8 && w < 2000) begin
      @(negedge mclk);
      w++;
      if (!p && txd) begin
        d[i] = rxd_line;
        i++;
      end
      p = txd;
    end
    if (i < 8) d = 'x;
  endtask

  // Shift register source: next bit shown after each clock fall
  task automatic put0(input logic [7:0] d);
    int w;
    int i;
    logic p;
    w = 0;
    i = 0;
    p = txd;
    while (i < 9 && w < 2000) begin
      @(posedge mclk);
      #1 w++;
      if (p && !txd && i < 8) begin
        drive = d[i];
        i++;
      end else if (!p && txd && i == 8) begin
        i++;
      end
      p = txd;
    end
    // Held until the last rise has taken the final bit
    drive = 1'b1;
  endtask
endmodule

`default_nettype wire

// ==== verif/spm_serial_port_monitor.sv ====
/*
  Port checker for the serial port.
  Assumes one clock, mclk, and the asynchronous active-high rst.
*/
`timescale 1ns/1ns
`default_nettype none

module spm_serial_port_monitor
  import spm_pkg::*;
#(
  parameter logic [7:0] BUF_ADDR = SPM_BUF_ADDR_DEF,
  parameter int FIFO_DEPTH = SPM_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register access
  input wire spm_sfr_s sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic tx_fifo_ready,
  // Selects and rate
  input wire logic err_access_select,
  input wire logic baud_double,
  input wire logic baud_tick16,
  // Pins
  input wire logic txd,
  input wire logic rxd_in,
  input wire logic rxd_out,
  input wire logic rxd_oe,
  input wire logic serial_irq
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  // Decoded strobes; a control write is the only way flags clear
  wire logic ctl_wr = sfr_req.wr && sfr_req.addr == SPM_CTRL_ADDR;
  wire logic ctl_rd = sfr_req.rd && sfr_req.addr == SPM_CTRL_ADDR;
  wire logic buf_wr = sfr_req.wr && sfr_req.addr == BUF_ADDR;
  wire logic bad_rd = sfr_req.rd && !ctl_rd && sfr_req.addr != BUF_ADDR;

  chk_irq_sticky: assert property (serial_irq && !ctl_wr |=> serial_irq)
    else $error("serial interrupt dropped without a control write");
  chk_unmapped_zero: assert property (bad_rd |=> sfr_rdata == 8'h00)
    else $error("unmapped read gave nonzero data");
  chk_rdata_hold: assert property (!sfr_req.rd |=> $stable(sfr_rdata))
    else $error("read data changed without a read");
  chk_ctrl_readback: assert property (ctl_wr && !err_access_select ##2
    ctl_rd && !err_access_select |=> sfr_rdata[7:3] == $past(sfr_req.wdata[7:3], 3))
    else $error("control bits 7..3 read back wrong");
  chk_async_start: assert property (!rxd_oe && $fell(txd) |-> !txd [*6])
    else $error("serial output low too briefly");
  chk_shift_clock: assert property (rxd_oe && $fell(txd) |-> !txd [*6] ##1 txd [*6])
    else $error("shift clock not six low then six high");
  chk_shift_data: assert property (rxd_oe && !txd && !$past(txd) |-> $stable(rxd_out))
    else $error("shift data moved inside the low phase");
  chk_fifo_fill: assert property ($fell(tx_fifo_ready) |-> $past(buf_wr))
    else $error("transmit queue filled without a buffer write");
endmodule

bind spm_serial_port spm_serial_port_monitor #(
  .BUF_ADDR(BUF_ADDR),
  .FIFO_DEPTH(FIFO_DEPTH)
) mon (
  .mclk(mclk), .rst(rst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
  .tx_fifo_ready(tx_fifo_ready), .err_access_select(err_access_select),
  .baud_double(baud_double), .baud_tick16(baud_tick16), .txd(txd), .rxd_in(rxd_in),
  .rxd_out(rxd_out), .rxd_oe(rxd_oe), .serial_irq(serial_irq)
);

`default_nettype wire

// ==== verif/test_serial_port_multiproc.sv ====
/*
  Bench for the serial port: register rows, then frames via a remote node.
  Assumes the node model and the bound monitor are compiled with it.
*/
`timescale 1ns/1ns
`default_nettype none

module test_serial_port_multiproc;
  import spm_pkg::*;
  localparam logic [7:0] C = SPM_CTRL_ADDR;
  localparam logic [7:0] B = SPM_BUF_ADDR_DEF;
  // Rows: select, write, address, data, expected read
  localparam logic [25:0] ROWS [5] = '{{2'b01, C, 8'hc0, 8'hc0}, {2'b11, C, 8'h40, 8'h40},
    {2'b00, C, 8'h00, 8'hc0}, {2'b01, 8'h9a, 8'h55, 8'h00}, {2'b01, C, 8'h00, 8'h00}};
  localparam logic [7:0] TCTL [3] = '{8'hd8, 8'h98, 8'h90};
  logic mclk, txd, rxd_out, rxd_oe, irq, rdy, drive;
  logic rst = 1'b1, sel = 1'b0, bd = 1'b0, tick = 1'b0;
  logic [7:0] v, rdata;
  logic [10:0] f;
  spm_sfr_s req = '0;
  int mismatches = 0, checks = 0, n;
  wire logic rxd_line;
  // Shared data line; the port drives it only in sync transmit
  assign rxd_line = rxd_oe ? rxd_out : drive;

  spm_serial_port dut (.mclk(mclk), .rst(rst), .sfr_req(req), .sfr_rdata(rdata),
    .tx_fifo_ready(rdy), .err_access_select(sel), .baud_double(bd), .baud_tick16(tick),
    .txd(txd), .rxd_in(rxd_line), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .serial_irq(irq));
  spm_remote_node node (.mclk(mclk), .txd(txd), .rxd_line(rxd_line), .drive(drive));

  // Clock, and a rate tick every other cycle: 32 cycles a bit
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) tick <= #1 ~tick;

  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask
  // Bus strobes; a free cycle follows each so strobes never re-rise at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{1'b1, 1'b0, a, d};
    cyc(1);
    req.wr = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    req = '{1'b0, 1'b1, a, 8'h00};
    cyc(1);
    req.rd = 1'b0;
    d = rdata;
    cyc(1);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Hang guard
  initial begin
    cyc(90000);
    mismatches++;
    final_report;
  end

  initial begin
    cyc(3);
    rst = 1'b0;
    chk({txd, rxd_oe, irq, rdy}, 11'h9);
    rd(C, v);
    chk(v, SPM_CTRL_RST);
    foreach (ROWS[i]) begin
      sel = ROWS[i][25];
      if (ROWS[i][24]) wr(ROWS[i][23:16], ROWS[i][15:8]);
      rd(ROWS[i][23:16], v);
      chk(v, ROWS[i][7:0]);
    end
    $display("test register rows done");
    // Full duplex frame in each direction
    wr(C, 8'h50);
    fork
      begin
        wr(B, 8'ha5);
        node.get(10, 32, f);
      end
      node.send({1'b1, 8'h3c, 1'b0}, 10, 32);
    join
    cyc(40);
    chk(f, {1'b1, 8'ha5, 1'b0});
    rd(C, v);
    chk({irq, v}, 9'h157);
    rd(B, v);
    chk(v, 8'h3c);
    // Second byte while the done flag of the first is still set
    node.send({1'b1, 8'h11, 1'b0}, 10, 32);
    cyc(40);
    rd(B, v);
    chk(v, 8'h3c);
    rd(C, v);
    chk(v, 8'h57);
    wr(C, 8'h40);
    node.send({1'b1, 8'h12, 1'b0}, 10, 32);
    cyc(40);
    rd(C, v);
    chk({irq, v}, 9'h040);
    $display("test async duplex done");
    // Missing stop bit, then a good frame
    wr(C, 8'h50);
    node.send({1'b0, 8'h5a, 1'b0}, 10, 32);
    cyc(40);
    sel = 1'b1;
    rd(C, v);
    chk(v, 8'hd1);
    sel = 1'b0;
    wr(C, 8'h50);
    node.send({1'b1, 8'h5b, 1'b0}, 10, 32);
    cyc(40);
    sel = 1'b1;
    rd(C, v);
    chk(v, 8'hd5);
    wr(C, 8'h50);
    rd(C, v);
    chk(v, 8'h50);
    sel = 1'b0;
    $display("test framing error done");
    // Nine-bit frames: mode 3, mode 2 fast, mode 2 slow
    for (int i = 0; i < 3; i++) begin
      bd = (i == 1);
      n = (i == 2) ? 64 : 32;
      wr(C, TCTL[i]);
      wr(B, 8'h90 + 8'(i));
      node.get(11, n, f);
      chk(f, {1'b1, TCTL[i][3], 8'h90 + 8'(i), 1'b0});
      cyc(n);
    end
    $display("test ninth bit done");
    // Data byte filtered, address byte passes, then filter off
    wr(C, 8'hf0);
    node.send({2'b10, 8'h44, 1'b0}, 11, 32);
    cyc(40);
    rd(C, v);
    chk({irq, v}, 9'h0f0);
    node.send({2'b11, 8'h21, 1'b0}, 11, 32);
    cyc(40);
    rd(C, v);
    chk({irq, v}, 9'h1f5);
    wr(C, 8'hd0);
    node.send({2'b10, 8'h77, 1'b0}, 11, 32);
    cyc(40);
    rd(B, v);
    chk(v, 8'h77);
    $display("test multiprocessor done");
    // Sync shift out
    wr(C, 8'h00);
    fork
      wr(B, 8'hc3);
      node.get0(v);
    join
    cyc(20);
    chk(v, 8'hc3);
    rd(C, v);
    chk(v, 8'h02);
    $display("test sync shift done");
    // Sync shift in: starts once enabled with the done flag clear
    wr(C, 8'h10);
    node.put0(8'h96);
    cyc(20);
    rd(B, v);
    chk(v, 8'h96);
    rd(C, v);
    chk(v, 8'h11);
    $display("test sync receive done");
    // Fill the queue until refused, drained by the node meanwhile
    wr(C, 8'h40);
    fork
      begin
        n = 0;
        while (rdy === 1'b1 && n < 20) begin
          wr(B, 8'(n));
          n++;
        end
        chk(11'(n), fill_count_exp());
        wr(B, 8'hee);
      end
      for (int i = 0; i < 17; i++) begin
        node.get(10, 32, f);
        chk(f, {1'b1, 8'(i), 1'b0});
      end
    join
    // The refused byte must never reach the line
    n = 0;
    repeat (400) begin
      cyc(1);
      if (txd !== 1'b1) n++;
    end
    chk(11'(n), 11'h0);
    chk(rdy, 1'b1);
    $display("test queue fill done");
    // Reset in mid-frame with every flag and the framing error set
    sel = 1'b1;
    wr(C, 8'hff);
    wr(B, 8'h3c);
    cyc(40);
    rst = 1'b1;
    cyc(2);
    chk({txd, rxd_oe, irq, rdy}, 11'h9);
    rst = 1'b0;
    rd(C, v);
    chk({irq, v}, 9'h000);
    sel = 1'b0;
    // A cut frame must not resume after reset
    n = 0;
    repeat (400) begin
      cyc(1);
      if (txd !== 1'b1) n++;
    end
    chk(11'(n), 11'h0);
    $display("test mid-run reset done");
    final_report;
  end

  // One byte leaves at once, so the queue takes one beyond its depth
  function automatic logic [10:0] fill_count_exp();
    return 11'(SPM_FIFO_DEPTH + 1);
  endfunction
endmodule

`default_nettype wire
